// >>> rtl/pdrc_top.sv
// Purpose: Power-down, power-up reset, output config and fuse control of a logic device
// Assumes: 125 MHz clk_i, synchronous active-high rst_i models the supply reset
// Notes:   Registers over classic Wishbone; JTAG pins sampled into clk_i
// Notes on behaviour
// [RULE_01] With power-down enabled, either chosen sleep request high puts the device asleep.
// [RULE_02] Power-down enable and its source, A, B or both, are configuration bits.
// [RULE_03] While asleep all internal signals and enabled outputs are held.
// [RULE_04] While asleep pin transitions are ignored until the request returns low.
// [RULE_05] A sleep request pin is no user input or output while power-down is enabled.
// [RULE_06] That pin's macrocell keeps serving foldback and cascade logic.
// [RULE_07] Each macrocell has a reduced-power bit, off after reset.
// [RULE_08] Each output has a slew bit, slow after reset, settable to fast.
// [RULE_09] Reset initialises every register; outputs follow their buffer polarity.
// [RULE_10] The system meets setup times before raising any clock after reset.
// [RULE_11] The system keeps clocks stable during reset settling.
// [RULE_12] With the fuse programmed, pattern readback is refused.
// [RULE_13] The 16-bit user signature stays readable whatever the fuse.
// [RULE_14] Configuration runs over the four-signal JTAG port; the code writes it over Wishbone, JTAG only reads and runs sessions.
// [RULE_15] An interrupted programming session locks the device with pins high-impedance.
// [RULE_16] Leaving power-down resumes from held state with no reinitialisation.
`timescale 1ns/1ps
`include "pdrc_map.svh"
module pdrc_top
   import pdrc_pkg::*;
#(
   parameter int unsigned SESS_TIMEOUT_CYC = `PDRC_SESS_TIMEOUT_US * `PDRC_CLK_MHZ,
   parameter logic [31:0] OUT_POLARITY     = `PDRC_OUT_POL_RST
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sleep_request_a_i,
   input  wire logic        sleep_request_b_i,
   input  wire logic        jtag_tck_i,
   input  wire logic        jtag_tms_i,
   input  wire logic        jtag_tdi_i,
   output logic             jtag_tdo_o,
   input  wire logic [31:0] pin_i,
   output logic      [31:0] pin_o,
   output logic      [31:0] pin_oe_o,
   input  wire logic [31:0] core_out_i,
   input  wire logic [31:0] core_oe_i,
   output logic      [31:0] core_in_o,
   output logic      [31:0] low_power_o,
   output logic      [31:0] slew_fast_o,
   output logic             sleeping_o
);
   localparam int unsigned PD_A = `PDRC_PD_A_IDX;
   localparam int unsigned PD_B = `PDRC_PD_B_IDX;
   localparam logic [23:0] SESS_LAST = 24'(SESS_TIMEOUT_CYC - 1);

   logic [2:0]  ctrl;
   logic [31:0] low_power;
   logic [31:0] slew_fast;
   logic        fuse;
   logic [15:0] signature;
   logic        refused;
   logic        sleeping;
   pdrc_sess_t  sess;
   logic [23:0] sess_cnt;
   logic [15:0] jshift;
   logic        tck_d;
   logic [36:0] sync_q;
   logic [31:0] pin_s;
   logic        req_a_s;
   logic        req_b_s;
   logic        tck_s;
   logic        tms_s;
   logic        tdi_s;
   logic        tck_rise;
   logic        jexec;
   logic [3:0]  jop;
   logic        wb_req;
   logic        wb_wr;
   logic        wb_rd;
   logic [31:0] pattern_word;
   logic [31:0] next_dat;
   logic        next_refuse;
   logic        pd_en;
   logic        src_a;
   logic        src_b;

   pdrc_hold_if hold ();

   // Clocks on the JTAG pins are only sampled; the system keeps them quiet in reset
   pdrc_sync #(.W (37)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({jtag_tdi_i, jtag_tms_i, jtag_tck_i, sleep_request_b_i, sleep_request_a_i,
               pin_i}),                                              // [RULE_11]
      .q_o   (sync_q)
   );

   assign pin_s   = sync_q[31:0];
   assign req_a_s = sync_q[32];
   assign req_b_s = sync_q[33];
   assign tck_s   = sync_q[34];
   assign tms_s   = sync_q[35];
   assign tdi_s   = sync_q[36];

   assign pd_en = ctrl[`PDRC_CTRL_EN];
   assign src_a = ctrl[`PDRC_CTRL_SRC_A];
   assign src_b = ctrl[`PDRC_CTRL_SRC_B];

   assign hold.freeze           = sleeping;                        // [RULE_03] [RULE_04]
   assign hold.lock             = (sess == PDRC_LOCKED);            // [RULE_15]
   always_comb begin
      hold.pd_mask       = 32'h0000_0000;
      hold.pd_mask[PD_A] = pd_en & src_a;                           // [RULE_05]
      hold.pd_mask[PD_B] = pd_en & src_b;                           // [RULE_05]
   end

   pdrc_pin_hold #(
      .OUT_POLARITY (OUT_POLARITY)
   ) u_hold (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .hold       (hold),
      .pin_sync_i (pin_s),
      .core_out_i (core_out_i),
      .core_oe_i  (core_oe_i),
      .core_in_o  (core_in_o),
      .pin_o      (pin_o),
      .pin_oe_o   (pin_oe_o)
   );

   // Sleep entry and exit; exit does not touch any held state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleeping   <= 1'b0;
         sleeping_o <= 1'b0;
      end else begin
         sleeping   <= pd_en & ((src_a & req_a_s) | (src_b & req_b_s));   // [RULE_01] [RULE_02]
         sleeping_o <= pd_en & ((src_a & req_a_s) | (src_b & req_b_s));   // [RULE_16]
      end
   end

   // Wishbone slave: single-cycle ack, unmapped addresses ack with zero
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i;
   assign wb_rd  = wb_req & ~wb_we_i;
   assign pattern_word = {slew_fast[15:0], low_power[15:0]};

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   always_comb begin
      next_dat    = 32'h0000_0000;
      next_refuse = 1'b0;
      case (wb_adr_i)
         `PDRC_ADDR_CTRL: begin
            next_dat[2:0] = ctrl;
         end
         `PDRC_ADDR_STATUS: begin
            next_dat[`PDRC_ST_SLEEP]   = sleeping;
            next_dat[`PDRC_ST_FUSE]    = fuse;
            next_dat[`PDRC_ST_LOCK]    = (sess == PDRC_LOCKED);
            next_dat[`PDRC_ST_SESS]    = (sess == PDRC_ACTIVE);
            next_dat[`PDRC_ST_REFUSED] = refused;
         end
         `PDRC_ADDR_LOWPWR: begin
            next_dat = low_power;
         end
         `PDRC_ADDR_SLEW: begin
            next_dat = slew_fast;
         end
         `PDRC_ADDR_FUSE: begin
            next_dat[0] = fuse;
         end
         `PDRC_ADDR_SIG: begin
            next_dat[15:0] = signature;                             // [RULE_13]
         end
         `PDRC_ADDR_PATTERN: begin
            next_dat    = fuse ? 32'h0000_0000 : pattern_word;      // [RULE_12]
            next_refuse = fuse;
         end
         default: begin
            next_dat = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_rd ? next_dat : 32'h0000_0000;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl      <= `PDRC_CTRL_RST;                               // [RULE_09]
         low_power <= `PDRC_LOWPWR_RST;                             // [RULE_07]
         slew_fast <= `PDRC_SLEW_RST;                               // [RULE_08]
         signature <= `PDRC_SIG_RST;
      end else if (wb_wr) begin
         if (wb_adr_i == `PDRC_ADDR_CTRL && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[2:0];                                  // [RULE_02]
         end
         if (wb_adr_i == `PDRC_ADDR_LOWPWR) begin
            low_power <= merge(low_power, wb_dat_i, wb_sel_i);      // [RULE_07]
         end
         if (wb_adr_i == `PDRC_ADDR_SLEW) begin
            slew_fast <= merge(slew_fast, wb_dat_i, wb_sel_i);      // [RULE_08]
         end
         if (wb_adr_i == `PDRC_ADDR_SIG) begin
            signature <= 16'(merge({16'h0000, signature}, wb_dat_i, wb_sel_i));
         end
      end
   end

   assign low_power_o = low_power;
   assign slew_fast_o = slew_fast;

   // Fuse only ever sets until the next reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse <= 1'b0;
      end else if (wb_wr && wb_adr_i == `PDRC_ADDR_FUSE && wb_sel_i[0] && wb_dat_i[0]) begin
         fuse <= 1'b1;
      end
   end

   // Refused flag: write one to clear, a new refusal in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refused <= 1'b0;
      end else if ((wb_rd && next_refuse) || (jexec && jop == `PDRC_OP_VERIFY && fuse)) begin
         refused <= 1'b1;                                           // [RULE_12]
      end else if (wb_wr && wb_adr_i == `PDRC_ADDR_STATUS && wb_sel_i[0]
                   && wb_dat_i[`PDRC_ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // JTAG port, sampled: tms high on a tck rise executes the shifted opcode
   assign tck_rise = tck_s & ~tck_d;
   assign jexec    = tck_rise & tms_s;                              // [RULE_14]
   assign jop      = jshift[3:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jshift     <= 16'h0000;
         jtag_tdo_o <= 1'b0;
      end else if (jexec) begin
         case (jop)
            `PDRC_OP_SIG:    jshift <= signature;                   // [RULE_13]
            `PDRC_OP_VERIFY: jshift <= fuse ? 16'h0000 : pattern_word[15:0];   // [RULE_12]
            default:         jshift <= 16'h0000;
         endcase
      end else if (tck_rise) begin
         jshift     <= {tdi_s, jshift[15:1]};                       // [RULE_14]
         jtag_tdo_o <= jshift[0];
      end
   end

   // Programming session; silence for too long means it was interrupted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sess <= PDRC_IDLE;
      end else begin
         unique case (sess)
            PDRC_IDLE: begin
               if (jexec && jop == `PDRC_OP_PROG_START) begin
                  sess <= PDRC_ACTIVE;
               end
            end
            PDRC_ACTIVE: begin
               if (jexec && jop == `PDRC_OP_PROG_END) begin
                  sess <= PDRC_IDLE;
               end else if (sess_cnt == SESS_LAST) begin
                  sess <= PDRC_LOCKED;                              // [RULE_15]
               end
            end
            PDRC_LOCKED: begin
               if (jexec && jop == `PDRC_OP_PROG_START) begin
                  sess <= PDRC_ACTIVE;
               end
            end
            default: begin
               sess <= PDRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sess_cnt <= 24'h00_0000;
      end else if (sess != PDRC_ACTIVE || tck_rise) begin
         sess_cnt <= 24'h00_0000;
      end else begin
         sess_cnt <= sess_cnt + 24'h00_0001;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence leave_s;
      sleeping ##1 !sleeping;
   endsequence

   sequence start_s;
      jexec && jop == `PDRC_OP_PROG_START && sess != PDRC_ACTIVE;
   endsequence

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   sleep_entry_a: assert property (pd_en && ((src_a && req_a_s) || (src_b && req_b_s))   // [RULE_01]
                                   |=> sleeping && sleeping_o)
      else $error("sleep request did not put the device asleep");
   sleep_source_a: assert property (!pd_en |=> !sleeping)          // [RULE_02]
      else $error("asleep with power-down disabled");
   freeze_hold_a: assert property (sleeping |=> $stable(pin_o) && $stable(pin_oe_o))   // [RULE_03]
      else $error("outputs moved while asleep");
   input_ignored_a: assert property (sleeping |=> $stable(core_in_o))   // [RULE_04]
      else $error("pin input reached the core while asleep");
   pd_pin_off_a: assert property ($past(pd_en && src_a) && !$past(hold.lock)  // [RULE_05]
                                  && !$past(sleeping) |-> !pin_oe_o[PD_A] && !core_in_o[PD_A])
      else $error("sleep pin used as user pin");
   lowpwr_reset_a: assert property ($past(rst_i) |-> low_power_o == `PDRC_LOWPWR_RST)   // [RULE_07]
      else $error("reduced-power bits not off after reset");
   slew_reset_a: assert property ($past(rst_i) |-> slew_fast_o == `PDRC_SLEW_RST)   // [RULE_08]
      else $error("slew bits not slow after reset");
   reset_init_a: assert property ($past(rst_i) |-> pin_o == OUT_POLARITY   // [RULE_09]
                                  && pin_oe_o == 32'h0000_0000 && !sleeping)
      else $error("outputs not at buffer polarity after reset");
   verify_block_a: assert property (wb_rd && fuse && wb_adr_i == `PDRC_ADDR_PATTERN   // [RULE_12]
                                    |=> wb_ack_o && wb_dat_o == 32'h0000_0000 && refused)
      else $error("pattern readable with fuse set");
   sig_read_a: assert property (wb_rd && wb_adr_i == `PDRC_ADDR_SIG   // [RULE_13]
                                |=> wb_ack_o && wb_dat_o == {16'h0000, $past(signature)})
      else $error("signature not returned");
   sess_start_a: assert property (start_s |=> sess == PDRC_ACTIVE)   // [RULE_14]
      else $error("programming start not taken");
   lock_hiz_a: assert property (sess == PDRC_LOCKED |=> pin_oe_o == 32'h0000_0000)   // [RULE_15]
      else $error("pins driven while locked");
   resume_a: assert property (leave_s |-> $stable(pin_o) && $stable(core_in_o))   // [RULE_16]
      else $error("state disturbed on leaving sleep");
endmodule

// >>> rtl/pdrc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes:   Definitions only
`ifndef PDRC_MAP_SVH
`define PDRC_MAP_SVH

`define PDRC_CELLS            32
`define PDRC_ADDR_CTRL        8'h00
`define PDRC_ADDR_STATUS      8'h04
`define PDRC_ADDR_LOWPWR      8'h08
`define PDRC_ADDR_SLEW        8'h0C
`define PDRC_ADDR_FUSE        8'h10
`define PDRC_ADDR_SIG         8'h14
`define PDRC_ADDR_PATTERN     8'h18

`define PDRC_CTRL_EN          0
`define PDRC_CTRL_SRC_A       1
`define PDRC_CTRL_SRC_B       2
`define PDRC_ST_SLEEP         0
`define PDRC_ST_FUSE          1
`define PDRC_ST_LOCK          2
`define PDRC_ST_SESS          3
`define PDRC_ST_REFUSED       4

`define PDRC_CTRL_RST         3'h0
`define PDRC_LOWPWR_RST       32'h0000_0000
`define PDRC_SLEW_RST         32'h0000_0000
`define PDRC_SIG_RST          16'h0000
`define PDRC_OUT_POL_RST      32'h0000_0000

// Macrocells whose pins double as sleep request inputs
`define PDRC_PD_A_IDX         8
`define PDRC_PD_B_IDX         24

`define PDRC_OP_SIG           4'h1
`define PDRC_OP_VERIFY        4'h2
`define PDRC_OP_PROG_START    4'h3
`define PDRC_OP_PROG_END      4'h4

`define PDRC_CLK_MHZ          125
`define PDRC_SESS_TIMEOUT_US  10000

`endif

// >>> rtl/pdrc_pkg.sv
// Purpose: Types shared by the power-down and reset control block
// Assumes: Nothing
// Notes:   Constants live in pdrc_map.svh
package pdrc_pkg;
   typedef enum logic [1:0] {PDRC_IDLE, PDRC_ACTIVE, PDRC_LOCKED} pdrc_sess_t;
endpackage

// >>> rtl/pdrc_hold_if.sv
// Purpose: Freeze, mask and lock controls from the control core to the pin stage
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
interface pdrc_hold_if;
   logic        freeze;
   logic [31:0] pd_mask;
   logic        lock;
   modport ctrl (output freeze, output pd_mask, output lock);
   modport pins (input freeze, input pd_mask, input lock);
endinterface

// >>> rtl/pdrc_sync.sv
// Purpose: Two-stage synchroniser per bit for pins entering the clock domain
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pdrc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            meta[i] <= 1'b0;
            q_o[i]  <= 1'b0;
         end else begin
            meta[i] <= d_i[i];
            q_o[i]  <= meta[i];
         end
      end
   end
endmodule

// >>> rtl/pdrc_pin_hold.sv
// Purpose: Per-pin hold stage: freezes inputs and outputs, masks sleep pins
// Assumes: Pin inputs already synchronised; core signals on clk_i
// Notes:   Core-side macrocell logic is untouched by the mask
`timescale 1ns/1ps
module pdrc_pin_hold #(
   parameter logic [31:0] OUT_POLARITY = 32'h0000_0000
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   pdrc_hold_if.pins        hold,
   input  wire logic [31:0] pin_sync_i,
   input  wire logic [31:0] core_out_i,
   input  wire logic [31:0] core_oe_i,
   output logic      [31:0] core_in_o,
   output logic      [31:0] pin_o,
   output logic      [31:0] pin_oe_o
);
   for (genvar i = 0; i < 32; i++) begin : g_pin
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            core_in_o[i] <= 1'b0;
            pin_o[i]     <= OUT_POLARITY[i];
            pin_oe_o[i]  <= 1'b0;
         end else if (hold.lock) begin
            pin_oe_o[i]  <= 1'b0;                        // [RULE_15]
         end else if (!hold.freeze) begin
            // Mask only the pin path; foldback and cascade stay with the core
            core_in_o[i] <= hold.pd_mask[i] ? 1'b0 : pin_sync_i[i];   // [RULE_05] [RULE_06]
            pin_o[i]     <= core_out_i[i];
            pin_oe_o[i]  <= core_oe_i[i] & ~hold.pd_mask[i];          // [RULE_05]
         end
      end
   end
endmodule

// >>> test/pdrc_board.sv
// Purpose: Board-side model driving sleep requests, JTAG pins and pad inputs
// Assumes: Every change lands by non-blocking assignment after a clk_i rising edge
// Notes:   Tasks are called by the testbench
`timescale 1ns/1ps
module pdrc_board (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   output logic             req_a_o,
   output logic             req_b_o,
   output logic             tck_o,
   output logic             tms_o,
   output logic             tdi_o,
   output logic      [31:0] pin_o
);
   initial begin
      req_a_o = 1'b0;
      req_b_o = 1'b0;
      tck_o   = 1'b0; // Held low while reset settles
      tms_o   = 1'b0;
      tdi_o   = 1'b1;
      pin_o   = 32'h0000_0000;
   end

   task automatic set_req(input logic a, input logic b);
      @(posedge clk_i);
      req_a_o <= a;
      req_b_o <= b;
   endtask

   task automatic set_pins(input logic [31:0] v);
      @(posedge clk_i);
      pin_o <= v;
   endtask

   // Data settles 8 cycles before tck rises; slow tck so the sampler sees each edge
   task automatic jtag_bit(input logic tms, input logic tdi);
      @(posedge clk_i);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (8) @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      tck_o <= 1'b0;
      tdi_o <= ~tdi;
   endtask

   // Word shifted LSB first, then one execute tick
   task automatic jtag_op(input logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         jtag_bit(1'b0, v[i]);
      end
      jtag_bit(1'b1, 1'b0);
   endtask
endmodule

// >>> test/power_down_and_reset_control_test.sv
// Purpose: Self-checking bench for the power-down and reset control block
// Assumes: 125 MHz clock, session timeout shortened to 50 cycles
// Notes:   Assertions live in the design files
`timescale 1ns/1ps
`include "pdrc_map.svh"
module power_down_and_reset_control_test;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, dat_o, pin_out, pin_oe, core_in, lp, slew;
   logic [31:0] core_out = 32'h0000_0000, core_oe = 32'h0000_0000, pins, held_p, held_c;
   logic        ack, tdo, sleeping, ra, rb, tck, tms, tdi;
   int          n_errors = 0, total_checks = 0;

   pdrc_top #(.SESS_TIMEOUT_CYC(50)) i_dut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .sleep_request_a_i(ra), .sleep_request_b_i(rb), .jtag_tck_i(tck), .jtag_tms_i(tms),
      .jtag_tdi_i(tdi), .jtag_tdo_o(tdo), .pin_i(pins), .pin_o(pin_out), .pin_oe_o(pin_oe),
      .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in),
      .low_power_o(lp), .slew_fast_o(slew), .sleeping_o(sleeping));
   pdrc_board i_board (.clk_i(clk), .rst_i(rst), .req_a_o(ra), .req_b_o(rb), .tck_o(tck),
      .tms_o(tms), .tdi_o(tdi), .pin_o(pins));

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         wrap_up();
      end
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rdat);
   endtask

   task automatic test_reset();
      chk("low_power", 32'h0000_0000, lp);
      chk("slew", 32'h0000_0000, slew);
      chk("pin_out", `PDRC_OUT_POL_RST, pin_out);
      chk("pin_oe", 32'h0000_0000, pin_oe);
      rd_chk("ctrl", `PDRC_ADDR_CTRL, 32'h0000_0000);
      $display("test_reset done");
   endtask

   task automatic test_cfg();
      wb(1'b1, `PDRC_ADDR_LOWPWR, 32'hA5A5_0F0F);
      wb(1'b1, `PDRC_ADDR_SLEW, 32'h0000_8001);
      chk("low_power", 32'hA5A5_0F0F, lp);
      chk("slew", 32'h0000_8001, slew);
      rd_chk("lowpwr_rd", `PDRC_ADDR_LOWPWR, 32'hA5A5_0F0F);
      $display("test_cfg done");
   endtask

   task automatic test_source();
      logic [2:0] cfg [4] = '{3'h3, 3'h5, 3'h7, 3'h6};
      logic       s;
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, `PDRC_ADDR_CTRL, {29'h0, cfg[c]});
         for (int r = 1; r < 3; r++) begin
            i_board.set_req(r[0], r[1]);
            repeat (6) @(posedge clk);
            s = cfg[c][0] & |(cfg[c][2:1] & r[1:0]);
            chk("sleeping", {31'h0, s}, {31'h0, sleeping});
            i_board.set_req(1'b0, 1'b0);
            repeat (6) @(posedge clk);
         end
      end
      $display("test_source done");
   endtask

   task automatic test_freeze();
      core_oe  <= 32'hFFFF_FFFF;
      core_out <= 32'h1234_5678;
      i_board.set_pins(32'h0F0F_0F0F);
      wb(1'b1, `PDRC_ADDR_CTRL, 32'h0000_0003);
      repeat (4) @(posedge clk);
      chk("src_in", 32'h0000_0000, {31'h0, core_in[`PDRC_PD_A_IDX]});
      chk("src_oe", 32'h0000_0000, {31'h0, pin_oe[`PDRC_PD_A_IDX]});
      i_board.set_req(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      held_p = pin_out;
      held_c = core_in;
      core_out <= 32'h8765_4321;
      i_board.set_pins(32'hF0F0_F0F0);
      repeat (8) @(posedge clk);
      chk("held_pin", held_p, pin_out);
      chk("held_in", held_c, core_in);
      i_board.set_req(1'b0, 1'b0);
      repeat (8) @(posedge clk);
      chk("wake_pin", 32'h8765_4321, pin_out);
      chk("wake_in", 32'hF0F0_F0F0, core_in);
      chk("wake_lp", 32'hA5A5_0F0F, lp);
      $display("test_freeze done");
   endtask

   task automatic test_fuse();
      rd_chk("pattern", `PDRC_ADDR_PATTERN, 32'h8001_0F0F);
      wb(1'b1, `PDRC_ADDR_SIG, 32'h0000_BEEF);
      wb(1'b1, `PDRC_ADDR_FUSE, 32'h0000_0001);
      rd_chk("pattern_fused", `PDRC_ADDR_PATTERN, 32'h0000_0000);
      rd_chk("status", `PDRC_ADDR_STATUS, 32'h0000_0012);
      rd_chk("signature", `PDRC_ADDR_SIG, 32'h0000_BEEF);
      wb(1'b1, `PDRC_ADDR_STATUS, 32'h0000_0010);
      rd_chk("status_clr", `PDRC_ADDR_STATUS, 32'h0000_0002);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      $display("test_fuse done");
   endtask

   // Execute an opcode, then shift 16 bits out of tdo, LSB first
   task automatic jtag_read(input logic [3:0] op, input logic [15:0] exp, input string what);
      logic [15:0] v;
      i_board.jtag_op({12'h000, op});
      for (int i = 0; i < 16; i++) begin
         i_board.jtag_bit(1'b0, 1'b0);
         v[i] = tdo;
      end
      chk(what, {16'h0000, exp}, {16'h0000, v});
   endtask

   task automatic test_jtag();
      jtag_read(`PDRC_OP_SIG, 16'hBEEF, "jtag_sig");
      jtag_read(`PDRC_OP_VERIFY, 16'h0000, "jtag_verify");
      rd_chk("jtag_refused", `PDRC_ADDR_STATUS, 32'h0000_0012);
      wb(1'b1, `PDRC_ADDR_STATUS, 32'h0000_0010);
      $display("test_jtag done");
   endtask

   task automatic test_session();
      wb(1'b1, `PDRC_ADDR_CTRL, 32'h0000_0000);
      i_board.jtag_op({12'h000, `PDRC_OP_PROG_START});
      rd_chk("session", `PDRC_ADDR_STATUS, 32'h0000_000A);
      repeat (60) @(posedge clk);
      rd_chk("locked", `PDRC_ADDR_STATUS, 32'h0000_0006);
      chk("lock_oe", 32'h0000_0000, pin_oe);
      i_board.jtag_op({12'h000, `PDRC_OP_PROG_START});
      i_board.jtag_op({12'h000, `PDRC_OP_PROG_END});
      rd_chk("unlocked", `PDRC_ADDR_STATUS, 32'h0000_0002);
      $display("test_session done");
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_cfg();
      test_source();
      test_freeze();
      test_fuse();
      test_jtag();
      test_session();
      wrap_up();
   end
endmodule
